// ===== acp_pkg.sv
/*
 Constants for the amplifier two-wire control and diagnostic port.
 Assumes one system clock of 20 MHz and a serial link clocked by the host.
*/
package acp_pkg;
    localparam logic [4:0] ACP_ADDR_HI = 5'h1b;
    localparam logic [7:0] ACP_CTRL1_RST = 8'h00;
    localparam logic [7:0] ACP_CTRL2_RST = 8'h00;
    localparam int ACP_C1_MUTE_TH = 7;
    localparam int ACP_C1_DIAG_EN = 6;
    localparam int ACP_C1_OFFS_EN = 5;
    localparam int ACP_C1_GAIN_F = 4;
    localparam int ACP_C1_GAIN_R = 3;
    localparam int ACP_C1_UNMUTE_F = 2;
    localparam int ACP_C1_UNMUTE_R = 1;
    localparam int ACP_C1_CLIP_TH = 0;
    localparam int ACP_C2_CUR_TH = 7;
    localparam int ACP_C2_ZERO = 6;
    localparam int ACP_C2_FAST_MUTE = 5;
    localparam int ACP_C2_RUN = 4;
    localparam int ACP_C2_LINE_DIAG = 3;
    localparam int ACP_C2_CUR_DIAG = 2;
    localparam int ACP_C2_HE_RIGHT = 1;
    localparam int ACP_C2_HE_LEFT = 0;
    localparam logic [1:0] ACP_STRAP_OPEN = 2'h3;
    typedef enum logic [2:0] {
        ACP_IDLE = 3'b000,
        ACP_ADDR = 3'b001,
        ACP_WRITE = 3'b010,
        ACP_READ = 3'b011,
        ACP_RACK = 3'b100,
        ACP_IGNORE = 3'b101
    } acp_state_t;
endpackage : acp_pkg

// ===== acp_port.sv
/*
 Two-wire slave port with control and diagnostic bytes.
 Assumes the host makes SCL; the link logic runs on SCL and on SDA edges
 sampled against it, while the amplifier controls live on CLK.
*/
`timescale 1ns/1ps
module acp_port
    import acp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [1:0] ADDRESS_STRAP_PIN,
    input wire logic [2:0] THERMAL_WARN,
    input wire logic DIAG_DONE,
    input wire logic [23:0] CHANNEL_FAULTS,
    output logic [7:0] AMP_CONTROL_FIRST,
    output logic [7:0] AMP_CONTROL_SECOND,
    output logic DIAG_RESTART
);
    // Link domain: start/stop detection on SDA edges while SCL high
    logic start_tgl_ff;
    logic stop_tgl_ff;
    logic rst_l1_ff;
    logic rst_l2_ff;
    logic link_rst;

    // Reset carried into link domain on SCL
    always_ff @(posedge SCL) begin
        rst_l1_ff <= RST;
        rst_l2_ff <= rst_l1_ff;
    end
    assign link_rst = rst_l2_ff;

    always_ff @(negedge SDA_IN or posedge link_rst) begin
        if (link_rst) begin
            start_tgl_ff <= 1'b0;
        end else if (SCL) begin
            start_tgl_ff <= ~start_tgl_ff;
        end
    end
    always_ff @(posedge SDA_IN or posedge link_rst) begin
        if (link_rst) begin
            stop_tgl_ff <= 1'b0;
        end else if (SCL) begin
            stop_tgl_ff <= ~stop_tgl_ff;
        end
    end

    logic start_seen_ff;
    logic stop_seen_ff;
    logic start_pend;
    logic stop_pend;
    assign start_pend = start_tgl_ff ^ start_seen_ff;
    assign stop_pend = stop_tgl_ff ^ stop_seen_ff;

    acp_state_t state_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [1:0] byte_cnt_ff;
    logic [7:0] c1_link_ff;
    logic [7:0] c2_link_ff;
    logic wr_tgl_ff;
    logic rd_tgl_ff;
    logic [1:0] strap_l_ff;
    logic [7:0] rx_byte;
    logic addr_match;

    assign rx_byte = {shift_ff[6:0], SDA_IN};
    assign addr_match = (strap_l_ff != ACP_STRAP_OPEN)
        && (shift_ff[6:0] == {ACP_ADDR_HI, strap_l_ff});

    // Sampling on rising SCL, MSB first
    always_ff @(posedge SCL) begin
        if (link_rst) begin
            state_ff <= ACP_IDLE;
            bit_cnt_ff <= 3'h0;
            shift_ff <= 8'h00;
            byte_cnt_ff <= 2'h0;
            start_seen_ff <= start_tgl_ff;
            stop_seen_ff <= stop_tgl_ff;
            c1_link_ff <= ACP_CTRL1_RST;
            c2_link_ff <= ACP_CTRL2_RST;
            wr_tgl_ff <= 1'b0;
            rd_tgl_ff <= 1'b0;
        end else if (start_pend) begin
            start_seen_ff <= start_tgl_ff;
            stop_seen_ff <= stop_tgl_ff;
            state_ff <= ACP_ADDR;
            shift_ff <= {7'h00, SDA_IN};
            bit_cnt_ff <= 3'h1;
            byte_cnt_ff <= 2'h0;
        end else if (stop_pend) begin
            stop_seen_ff <= stop_tgl_ff;
            state_ff <= ACP_IDLE;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            unique case (state_ff)
                ACP_IDLE, ACP_IGNORE: begin
                    bit_cnt_ff <= 3'h0;
                end
                ACP_ADDR: begin
                    shift_ff <= rx_byte;
                    if (bit_cnt_ff == 3'h7) begin
                        // Ack slot follows; next state entered now, ahead of it
                        if (!addr_match) begin
                            state_ff <= ACP_IGNORE;
                        end else if (SDA_IN) begin
                            state_ff <= ACP_READ;
                            shift_ff <= diag_byte(2'h0);
                        end else begin
                            state_ff <= ACP_WRITE;
                        end
                        bit_cnt_ff <= 3'h0;
                    end
                end
                ACP_WRITE: begin
                    if (ack_slot_ff) begin
                        // Ack pulse carries no data bit
                        bit_cnt_ff <= 3'h0;
                    end else begin
                        shift_ff <= rx_byte;
                        if (bit_cnt_ff == 3'h7) begin
                            if (byte_cnt_ff == 2'h0) begin
                                c1_link_ff <= rx_byte;
                            end else if (byte_cnt_ff == 2'h1) begin
                                c2_link_ff <= rx_byte;
                                wr_tgl_ff <= ~wr_tgl_ff;
                            end
                            if (byte_cnt_ff != 2'h3) begin
                                byte_cnt_ff <= byte_cnt_ff + 2'h1;
                            end
                        end
                    end
                end
                ACP_READ: begin
                    if (ack_slot_ff) begin
                        // Address ack pulse; first bit goes out after it
                        bit_cnt_ff <= 3'h0;
                    end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        if (bit_cnt_ff == 3'h7) begin
                            state_ff <= ACP_RACK;
                        end
                    end
                end
                ACP_RACK: begin
                    // Host ack sampled; low continues unless the fourth byte was sent
                    if (!SDA_IN && byte_cnt_ff != 2'h3) begin
                        byte_cnt_ff <= byte_cnt_ff + 2'h1;
                        shift_ff <= diag_byte(byte_cnt_ff + 2'h1);
                        state_ff <= ACP_READ;
                    end else begin
                        if (byte_cnt_ff == 2'h3) begin
                            rd_tgl_ff <= ~rd_tgl_ff;
                        end
                        state_ff <= ACP_IGNORE;
                    end
                    bit_cnt_ff <= 3'h0;
                end
                default: state_ff <= ACP_IDLE;
            endcase
        end
    end

    // Ack window tracking; ack bit follows byte at count 7
    logic ack_slot_ff;
    always_ff @(posedge SCL) begin
        if (link_rst || start_pend || stop_pend) begin
            ack_slot_ff <= 1'b0;
        end else begin
            ack_slot_ff <= (bit_cnt_ff == 3'h7) && (state_ff == ACP_WRITE
                || (state_ff == ACP_ADDR && addr_match));
        end
    end

    // Drive changes only on falling SCL
    logic drv_low_ff;
    always_ff @(negedge SCL) begin
        if (link_rst) begin
            drv_low_ff <= 1'b0;
        end else if (ack_slot_ff) begin
            drv_low_ff <= 1'b1;
        end else if (state_ff == ACP_READ) begin
            drv_low_ff <= ~shift_ff[7];
        end else begin
            drv_low_ff <= 1'b0;
        end
    end
    assign SDA_OUT = 1'b0;
    assign SDA_OE = drv_low_ff;

    // System domain: strap, diagnostics snapshot and controls
    logic [1:0] strap_s1_ff;
    logic [1:0] strap_s2_ff;
    logic [1:0] strap_s3_ff;
    logic [1:0] strap_f_ff;
    always_ff @(posedge CLK) begin
        if (RST) begin
            strap_s1_ff <= ACP_STRAP_OPEN;
            strap_s2_ff <= ACP_STRAP_OPEN;
            strap_s3_ff <= ACP_STRAP_OPEN;
            strap_f_ff <= ACP_STRAP_OPEN;
        end else begin
            strap_s1_ff <= ADDRESS_STRAP_PIN;
            strap_s2_ff <= strap_s1_ff;
            strap_s3_ff <= strap_s2_ff;
            if (strap_s2_ff == strap_s3_ff) begin
                strap_f_ff <= strap_s3_ff;
            end
        end
    end
    // Strap is static; link takes the filtered copy
    always_ff @(posedge SCL) begin
        strap_l_ff <= strap_f_ff;
    end

    logic [2:0] wr_sync_ff;
    logic [2:0] rd_sync_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic [7:0] snap_ff [0:3];
    logic restart_ff;
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_sync_ff <= 3'h0;
            rd_sync_ff <= 3'h0;
        end else begin
            wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
            rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
        end
    end

    // Controls apply once both bytes landed; link copies stable by then
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl1_ff <= ACP_CTRL1_RST;
            ctrl2_ff <= ACP_CTRL2_RST;
        end else if (wr_sync_ff[2] != wr_sync_ff[1]) begin
            ctrl1_ff <= c1_link_ff;
            ctrl2_ff <= c2_link_ff & ~(8'h01 << ACP_C2_ZERO);
        end
    end
    assign AMP_CONTROL_FIRST = ctrl1_ff;
    assign AMP_CONTROL_SECOND = ctrl2_ff;

    // Snapshot holds previous cycle results until next read completes
    always_ff @(posedge CLK) begin
        if (RST) begin
            restart_ff <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                snap_ff[i] <= 8'h00;
            end
        end else begin
            restart_ff <= rd_sync_ff[2] != rd_sync_ff[1];
            if (rd_sync_ff[2] != rd_sync_ff[1]) begin
                snap_ff[0] <= {THERMAL_WARN[0], DIAG_DONE, CHANNEL_FAULTS[5:0]};
                snap_ff[1] <= {ctrl1_ff[ACP_C1_OFFS_EN], 1'b0, CHANNEL_FAULTS[11:6]};
                snap_ff[2] <= {ctrl2_ff[ACP_C2_RUN], ctrl1_ff[ACP_C1_DIAG_EN],
                    CHANNEL_FAULTS[17:12]};
                snap_ff[3] <= {THERMAL_WARN[1], THERMAL_WARN[2], CHANNEL_FAULTS[23:18]};
            end
        end
    end
    assign DIAG_RESTART = restart_ff;

    // Snapshot read from link; stable between reads
    function automatic logic [7:0] diag_byte(input logic [1:0] idx);
        diag_byte = snap_ff[idx];
    endfunction : diag_byte

    restart_pulse_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> DIAG_RESTART)
        else $error("diagnostic restart missing after read");
    zero_bit_a: assert property (@(posedge CLK) disable iff (RST)
        !AMP_CONTROL_SECOND[ACP_C2_ZERO])
        else $error("reserved control bit set");
    ctrl_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_sync_ff[2] == wr_sync_ff[1]) |=> $stable(AMP_CONTROL_FIRST))
        else $error("control changed without write");
    mirror_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[2][7] == $past(ctrl2_ff[ACP_C2_RUN]))
        else $error("standby mirror wrong");
    offs_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[1][7] == $past(ctrl1_ff[ACP_C1_OFFS_EN]))
        else $error("offset flag wrong");
    therm_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[3][7:6] == $past({THERMAL_WARN[1], THERMAL_WARN[2]}))
        else $error("thermal warning wrong");
    ack_drive_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_IGNORE) |-> ##1 !SDA_OE || ack_slot_ff)
        else $error("drive in ignore");
    done_bit_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[0][6] == $past(DIAG_DONE))
        else $error("cycle done bit wrong");

    // Link-side protocol checks
    start_addr_a: assert property (@(posedge SCL) disable iff (link_rst)
        start_pend |=> state_ff == ACP_ADDR)
        else $error("start not taken");
    stop_idle_a: assert property (@(posedge SCL) disable iff (link_rst)
        (stop_pend && !start_pend) |=> state_ff == ACP_IDLE)
        else $error("stop not taken");
    ack_low_a: assert property (@(posedge SCL) disable iff (link_rst)
        ack_slot_ff |-> SDA_OE)
        else $error("ack not driven low");
    rack_release_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_RACK) |-> !SDA_OE)
        else $error("data not released for host ack");
    read_bit_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_READ && !ack_slot_ff) |-> SDA_OE == !shift_ff[7])
        else $error("read bit wrong on line");
    read_dir_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_ADDR && !start_pend && !stop_pend && bit_cnt_ff == 3'h7
        && addr_match && SDA_IN) |=> state_ff == ACP_READ)
        else $error("read direction missed");
    write_dir_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_ADDR && !start_pend && !stop_pend && bit_cnt_ff == 3'h7
        && addr_match && !SDA_IN) |=> state_ff == ACP_WRITE)
        else $error("write direction missed");
    addr_ack_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_ADDR && !start_pend && !stop_pend && bit_cnt_ff == 3'h7
        && addr_match) |=> ack_slot_ff)
        else $error("matching address not acked");
    ignore_miss_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_ADDR && !start_pend && !stop_pend && bit_cnt_ff == 3'h7
        && !addr_match) |=> state_ff == ACP_IGNORE)
        else $error("foreign address not ignored");
    ignore_hold_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_IGNORE && !start_pend) |=> state_ff == ACP_IGNORE
        || state_ff == ACP_IDLE)
        else $error("left ignore without start");
    open_strap_a: assert property (@(posedge SCL) disable iff (link_rst)
        (strap_l_ff == ACP_STRAP_OPEN) |-> !addr_match)
        else $error("open strap still matches");
    read_next_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_RACK && !start_pend && !stop_pend && !SDA_IN
        && byte_cnt_ff != 2'h3) |=> state_ff == ACP_READ)
        else $error("next diagnostic byte not sent");
    read_end_a: assert property (@(posedge SCL) disable iff (link_rst)
        (state_ff == ACP_RACK && !start_pend && !stop_pend && byte_cnt_ff == 2'h3)
        |=> rd_tgl_ff != $past(rd_tgl_ff))
        else $error("completed read not flagged");

    // Control, restart pulse and snapshot checks
    c1_apply_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_sync_ff[2] != wr_sync_ff[1]) |=> AMP_CONTROL_FIRST == $past(c1_link_ff))
        else $error("first control byte not applied");
    c2_apply_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_sync_ff[2] != wr_sync_ff[1])
        |=> AMP_CONTROL_SECOND == ($past(c2_link_ff) & ~(8'h01 << ACP_C2_ZERO)))
        else $error("second control byte not applied");
    ctrl2_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_sync_ff[2] == wr_sync_ff[1]) |=> $stable(AMP_CONTROL_SECOND))
        else $error("second control changed without write");
    restart_once_a: assert property (@(posedge CLK) disable iff (RST)
        DIAG_RESTART |=> !DIAG_RESTART)
        else $error("restart pulse too long");
    snap_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] == rd_sync_ff[1]) |=> $stable(snap_ff[0]) && $stable(snap_ff[1])
        && $stable(snap_ff[2]) && $stable(snap_ff[3]))
        else $error("snapshot changed without read");
    warn1_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[0][7] == $past(THERMAL_WARN[0]))
        else $error("first thermal warning wrong");
    diag_mirror_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[2][6] == $past(ctrl1_ff[ACP_C1_DIAG_EN]))
        else $error("diagnostic mirror wrong");
    fl_faults_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[0][5:0] == $past(CHANNEL_FAULTS[5:0]))
        else $error("front left faults wrong");
    rl_faults_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[1][5:0] == $past(CHANNEL_FAULTS[11:6]))
        else $error("rear left faults wrong");
    fr_faults_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[2][5:0] == $past(CHANNEL_FAULTS[17:12]))
        else $error("front right faults wrong");
    rr_faults_a: assert property (@(posedge CLK) disable iff (RST)
        (rd_sync_ff[2] != rd_sync_ff[1]) |=> snap_ff[3][5:0] == $past(CHANNEL_FAULTS[23:18]))
        else $error("rear right faults wrong");
endmodule : acp_port

// ===== acp_host_model.sv
/*
 Host model: two-wire bus master that makes the link clock and drives data.
 Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps
module acp_host_model (
    output logic SCL,
    output logic SDA_OE,
    input wire logic SDA_LINE
);
    localparam realtime QTR = 3.75;

    initial begin
        SCL = 1'b1;
        SDA_OE = 1'b0;
    end

    // Clock stands high outside frames
    task automatic idle_clocks(input int n);
        repeat (n) begin
            SCL = 1'b0;
            #(2 * QTR) SCL = 1'b1;
            #(2 * QTR);
        end
    endtask : idle_clocks

    // Data moves mid-low, sampled mid-high
    task automatic put_bit(input logic b, output logic r);
        SCL = 1'b0;
        #QTR SDA_OE = ~b;
        #QTR SCL = 1'b1;
        #QTR r = SDA_LINE;
        #QTR;
    endtask : put_bit

    task automatic start_cond();
        SDA_OE = 1'b0;
        #(2 * QTR) SDA_OE = 1'b1;
        #(2 * QTR);
    endtask : start_cond

    task automatic stop_cond();
        SCL = 1'b0;
        #QTR SDA_OE = 1'b1;
        #QTR SCL = 1'b1;
        #(2 * QTR) SDA_OE = 1'b0;
        #(2 * QTR);
    endtask : stop_cond

    // Ack slot: release after sending, pull low when acking a read byte
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
        put_bit(ack_in, ack);
    endtask : xfer
endmodule : acp_host_model

// ===== tb_amp_i2c_control_diag_port.sv
/*
 Self-checking bench for the two-wire control and diagnostic port.
 Assumes acp_host_model as bus master and the acp_pkg constants.
*/
`timescale 1ns/1ps
module tb_amp_i2c_control_diag_port
    import acp_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, host_oe, dut_oe, dut_out, diag_restart;
    logic diag_done = 1'b0;
    logic [1:0] strap = 2'h0;
    logic [2:0] twarn = 3'h0;
    logic [23:0] faults = 24'h0;
    logic [7:0] ctrl1, ctrl2, q;
    logic [7:0] tx [4];
    logic [7:0] rx [4];
    logic acks [5];
    wire sda_line;
    int n_mismatch = 0;
    int checked = 0;
    int n_restart = 0;
    int exp_restart = 0;
    int seed, exp_c1 = 0, exp_c2 = 0;
    int wrote = 1;
    int snap [4] = '{0, 0, 0, 0};

    always #25 clk = ~clk;
    assign sda_line = host_oe ? 1'b0 : (dut_oe ? dut_out : 1'b1);

    acp_host_model i_host (.SCL(scl), .SDA_OE(host_oe), .SDA_LINE(sda_line));
    acp_port i_dut (.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(dut_out),
        .SDA_OE(dut_oe), .ADDRESS_STRAP_PIN(strap), .THERMAL_WARN(twarn),
        .DIAG_DONE(diag_done), .CHANNEL_FAULTS(faults), .AMP_CONTROL_FIRST(ctrl1),
        .AMP_CONTROL_SECOND(ctrl2), .DIAG_RESTART(diag_restart));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) if (diag_restart === 1'b1) n_restart++;
    always @(dut_oe) if (rst === 1'b0) check(scl, 1'b0);

    task automatic frame(input logic [7:0] addr, input int nb);
        i_host.start_cond();
        i_host.xfer(addr, 1'b1, q, acks[0]);
        for (int k = 0; k < nb; k++) begin
            i_host.xfer(addr[0] ? 8'hff : tx[k], !(addr[0] && k < nb - 1), rx[k],
                acks[k + 1]);
        end
        i_host.stop_cond();
        repeat (6) @(posedge clk);
    endtask : frame

    task automatic write_ctrl(input logic [7:0] c1, input logic [7:0] c2, input int nb);
        tx[0] = c1;
        tx[1] = c2;
        tx[2] = ~c1;
        frame({ACP_ADDR_HI, strap, 1'b0}, nb);
        for (int k = 0; k <= nb; k++) check(acks[k], 1'b0);
        if (nb >= 2) begin
            exp_c1 = c1;
            exp_c2 = c2 & 8'hbf;
            wrote = 1;
        end
        check(ctrl1, exp_c1);
        check(ctrl2, exp_c2);
    endtask : write_ctrl

    task automatic read_diag();
        int exp_b [4];
        exp_b = snap;
        if (wrote != 0) #1ms;
        wrote = 0;
        frame({ACP_ADDR_HI, strap, 1'b1}, 4);
        exp_restart++;
        check(acks[0], 1'b0);
        for (int k = 0; k < 4; k++) check(rx[k], exp_b[k][7:0]);
        snap[0] = {twarn[0], diag_done, faults[5:0]};
        snap[1] = {exp_c1[5], 1'b0, faults[11:6]};
        snap[2] = {exp_c2[4], exp_c1[6], faults[17:12]};
        snap[3] = {twarn[1], twarn[2], faults[23:18]};
        check(n_restart, exp_restart);
    endtask : read_diag

    initial begin
        seed = $urandom(32'h2f6cc33f);
        fork
            i_host.idle_clocks(6);
        join_none
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(ctrl1, ACP_CTRL1_RST);
        check(ctrl2, ACP_CTRL2_RST);
        check({dut_oe, diag_restart}, 2'b00);
        i_host.idle_clocks(3);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            strap <= 2'(i % 3);
            repeat (5) @(posedge clk);
            write_ctrl(i < 8 ? 8'h01 << i : 8'($urandom), i < 8 ? 8'h80 >> i : 8'($urandom), 2);
        end
        write_ctrl(8'h5a, 8'h3c, 1);
        write_ctrl(8'ha5, 8'h17, 3);
        $display("write test done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            strap <= i ? ACP_STRAP_OPEN : 2'h0;
            repeat (5) @(posedge clk);
            tx[0] = 8'h00;
            tx[1] = 8'h00;
            frame({ACP_ADDR_HI, i ? 2'h3 : 2'h1, 1'b0}, 2);
            for (int k = 0; k < 3; k++) check(acks[k], 1'b1);
            check(ctrl1, exp_c1);
            check(ctrl2, exp_c2);
        end
        $display("refusal test done");
        @(posedge clk);
        strap <= 2'h2;
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            twarn <= 3'($urandom);
            diag_done <= 1'($urandom);
            faults <= 24'($urandom);
            repeat (5) @(posedge clk);
            if (r == 2) write_ctrl(8'($urandom), 8'($urandom), 2);
            read_diag();
        end
        $display("read test done");
        tally_and_finish();
    end

    initial begin
        #4ms;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_amp_i2c_control_diag_port
